// File: src/timer_core.sv
// The register offsets and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/10ps
`include "timer_core_cfg.svh"
module timer_core (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic crystal_pin_one,
   input wire logic [2:0] irq_ack,
   output logic irq,
   output logic compare_output_a,
   output logic compare_output_b
);
   ////////////////////////////////////////////////////////////////////////////
   function automatic logic mapped(input logic [7:0] a);
      mapped = (a == `TC_OFF_CTRL_A) | (a == `TC_OFF_CTRL_B) | (a == `TC_OFF_COUNT) |
               (a == `TC_OFF_CMP_A) | (a == `TC_OFF_CMP_B) | (a == `TC_OFF_FLAG) |
               (a == `TC_OFF_MASK) | (a == `TC_OFF_ASYNC) | (a == `TC_OFF_POWER);
   endfunction

   logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q, irq_q;
   logic aw_have_q, w_have_q;
   logic [7:0] awaddr_q;
   logic [7:0] wdata_q;
   logic wstrb_q;
   logic [1:0] bresp_q, rresp_q;
   logic [31:0] rdata_q;
   logic [1:0] wgm_lo_q;
   logic wgm_hi_q;
   logic [2:0] cs_q;
   logic [7:0] count_q, cmp_a_q, cmp_b_q;
   logic [`TC_FLAG_W-1:0] flag_q, mask_q;
   logic async_q, power_q, down_q, block_q;

   ////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite write path: address and data are taken independently.
   wire aw_fire = s_axi_awvalid & awready_q;
   wire w_fire = s_axi_wvalid & wready_q;
   wire wr_do = aw_have_q & w_have_q & ~bvalid_q;
   wire aw_have_d = wr_do ? 1'b0 : (aw_have_q | aw_fire);
   wire w_have_d = wr_do ? 1'b0 : (w_have_q | w_fire);
   wire bvalid_d = wr_do | (bvalid_q & ~s_axi_bready);
   wire wr_en = wr_do & wstrb_q;
   wire wr_ctrl_a = wr_en & (awaddr_q == `TC_OFF_CTRL_A);
   wire wr_ctrl_b = wr_en & (awaddr_q == `TC_OFF_CTRL_B);
   wire wr_count = wr_en & (awaddr_q == `TC_OFF_COUNT);
   wire wr_cmp_a = wr_en & (awaddr_q == `TC_OFF_CMP_A);
   wire wr_cmp_b = wr_en & (awaddr_q == `TC_OFF_CMP_B);
   wire wr_flag = wr_en & (awaddr_q == `TC_OFF_FLAG);
   wire wr_mask = wr_en & (awaddr_q == `TC_OFF_MASK);
   wire wr_async = wr_en & (awaddr_q == `TC_OFF_ASYNC);
   wire wr_power = wr_en & (awaddr_q == `TC_OFF_POWER);

   // Read path: one read at a time, answered one cycle after the address.
   wire rd_do = s_axi_arvalid & arready_q;
   wire rvalid_d = rd_do | (rvalid_q & ~s_axi_rready);
   wire rd_flag = rd_do & (s_axi_araddr == `TC_OFF_FLAG);
   wire [7:0] rd_byte =
      (s_axi_araddr == `TC_OFF_CTRL_A) ? {6'h00, wgm_lo_q} :
      (s_axi_araddr == `TC_OFF_CTRL_B) ? {4'h0, wgm_hi_q, cs_q} :
      (s_axi_araddr == `TC_OFF_COUNT) ? count_q :
      (s_axi_araddr == `TC_OFF_CMP_A) ? cmp_a_q :
      (s_axi_araddr == `TC_OFF_CMP_B) ? cmp_b_q :
      (s_axi_araddr == `TC_OFF_FLAG) ? {5'h00, flag_q} :
      (s_axi_araddr == `TC_OFF_MASK) ? {5'h00, mask_q} :
      (s_axi_araddr == `TC_OFF_ASYNC) ? {7'h00, async_q} :
      (s_axi_araddr == `TC_OFF_POWER) ? {7'h00, power_q} : 8'h00;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         awready_q <= 1'b0;
         wready_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= `TC_RESP_OKAY;
         awaddr_q <= 8'h00;
         wdata_q <= 8'h00;
         wstrb_q <= 1'b0;
      end else begin
         aw_have_q <= aw_have_d;
         w_have_q <= w_have_d;
         awready_q <= ~aw_have_d & ~bvalid_d;
         wready_q <= ~w_have_d & ~bvalid_d;
         bvalid_q <= bvalid_d;
         if (aw_fire) awaddr_q <= s_axi_awaddr;
         if (w_fire) wdata_q <= s_axi_wdata[7:0];
         if (w_fire) wstrb_q <= s_axi_wstrb[0];
         if (wr_do) bresp_q <= mapped(awaddr_q) ? `TC_RESP_OKAY : `TC_RESP_SLVERR;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_q <= 1'b0;
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= `TC_RESP_OKAY;
      end else begin
         arready_q <= ~rvalid_d;
         rvalid_q <= rvalid_d;
         if (rd_do) rdata_q <= {24'h000000, rd_byte};
         if (rd_do) rresp_q <= mapped(s_axi_araddr) ? `TC_RESP_OKAY : `TC_RESP_SLVERR;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Configuration registers.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wgm_lo_q <= 2'h0;
         wgm_hi_q <= 1'b0;
         cs_q <= 3'h0;
         cmp_a_q <= `TC_RST_BYTE;
         cmp_b_q <= `TC_RST_BYTE;
         mask_q <= 3'h0;
         async_q <= 1'b0;
         power_q <= `TC_RST_POWER;
      end else begin
         if (wr_ctrl_a) wgm_lo_q <= wdata_q[`TC_WGM_LO_LSB +: 2];
         if (wr_ctrl_b) wgm_hi_q <= wdata_q[`TC_WGM_HI_BIT];
         if (wr_ctrl_b) cs_q <= wdata_q[`TC_CS_LSB +: 3];
         if (wr_cmp_a) cmp_a_q <= wdata_q;
         if (wr_cmp_b) cmp_b_q <= wdata_q;
         if (wr_mask) mask_q <= wdata_q[`TC_FLAG_W-1:0];
         if (wr_async) async_q <= wdata_q[`TC_ASYNC_BIT];
         if (wr_power) power_q <= wdata_q[`TC_POWER_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Counter unit.
   logic tick;
   tick_select u_tick (
      .aclk(aclk),
      .aresetn(aresetn),
      .async_clock_select(async_q),
      .clock_select_field(cs_q),
      .enable(~power_q),
      .crystal_pin_one(crystal_pin_one),
      .tick(tick)
   );

   timer_pkg::mode_e mode;
   assign mode = timer_pkg::mode_e'({wgm_hi_q, wgm_lo_q});
   wire top_is_a = (mode == timer_pkg::mode_ctc) | (mode == timer_pkg::mode_pc_top) |
                   (mode == timer_pkg::mode_fast_top);
   wire [7:0] top_val = top_is_a ? cmp_a_q : `TC_MAX;
   wire at_bottom = (count_q == `TC_BOTTOM);
   wire at_max = (count_q == `TC_MAX);
   wire at_top = (count_q == top_val);
   wire phase = (mode == timer_pkg::mode_pc_max) | (mode == timer_pkg::mode_pc_top);
   wire fast = (mode == timer_pkg::mode_fast_max) | (mode == timer_pkg::mode_fast_top);
   wire clear = tick & (mode == timer_pkg::mode_ctc | fast) & at_top;
   wire dir_down = phase & (down_q | at_top) & ~at_bottom;
   wire [7:0] count_step = dir_down ? count_q - 8'h01 : count_q + 8'h01;
   wire ovf_event = tick & ((phase & at_bottom & down_q) |
                            (fast & at_top) |
                            (~phase & ~fast & at_max));
   wire match_a = tick & ~block_q & (count_q == cmp_a_q);
   wire match_b = tick & ~block_q & (count_q == cmp_b_q);
   wire [2:0] set_flags = {match_b, match_a, ovf_event};
   wire [2:0] clr_flags = irq_ack | (wr_flag ? wdata_q[2:0] : 3'h0) |
                          (rd_flag ? flag_q : 3'h0);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count_q <= `TC_RST_BYTE;
         down_q <= 1'b0;
         block_q <= 1'b0;
      end else begin
         if (wr_count) begin
            count_q <= wdata_q;
         end else if (clear) begin
            count_q <= `TC_BOTTOM;
         end else if (tick) begin
            count_q <= count_step;
         end
         if (tick) down_q <= dir_down;
         if (wr_count) begin
            block_q <= 1'b1;
         end else if (tick) begin
            block_q <= 1'b0;
         end
      end
   end

   // A set in the same cycle as a clear wins.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flag_q <= 3'h0;
         irq_q <= 1'b0;
      end else begin
         flag_q <= (flag_q & ~clr_flags) | set_flags;
         irq_q <= |(((flag_q & ~clr_flags) | set_flags) & mask_q);
      end
   end

   wave_gen u_wave (
      .aclk(aclk),
      .aresetn(aresetn),
      .tick(tick),
      .mode(mode),
      .count(count_q),
      .compare_a(cmp_a_q),
      .compare_b(cmp_b_q),
      .compare_output_a(compare_output_a),
      .compare_output_b(compare_output_b)
   );

   assign s_axi_awready = awready_q;
   assign s_axi_wready = wready_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_arready = arready_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;
   assign irq = irq_q;

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_stop_holds: assert property ((cs_q == 3'h0) & ~wr_count |=> $stable(count_q))
      else $error("counter moved with no clock selected");
   a_write_wins: assert property (wr_count |=> count_q == $past(wdata_q))
      else $error("counter write did not take priority");
   a_count_step: assert property (tick & ~wr_count & ~clear & (mode == timer_pkg::mode_normal)
      |=> count_q == $past(count_q) + 8'h01)
      else $error("normal mode did not step up by one");
   a_ctc_clear: assert property (tick & ~wr_count & (mode == timer_pkg::mode_ctc)
      & (count_q == cmp_a_q) |=> count_q == 8'h00)
      else $error("ctc did not clear at compare a");
   a_ovf_wrap: assert property (tick & (mode == timer_pkg::mode_normal) & (count_q == 8'hff)
      |=> flag_q[0])
      else $error("overflow flag not set on wrap");
   a_cmp_flag: assert property (tick & ~block_q & (count_q == cmp_b_q) |=> flag_q[2])
      else $error("compare b flag not set after match");
   a_block_match: assert property (wr_count ##1 tick & (count_q == cmp_a_q)
      & ~flag_q[1] & ~irq_ack[1] |=> ~flag_q[1])
      else $error("match after counter write was not blocked");
   a_irq_mask: assert property (##1 irq == $past(|((flag_q & ~clr_flags | set_flags) & mask_q)))
      else $error("interrupt does not follow masked flags");
   a_ack_clear: assert property (irq_ack[0] & ~ovf_event |=> ~flag_q[0])
      else $error("overflow flag not cleared by ack");
   a_power_off: assert property (power_q |-> ~tick)
      else $error("tick while module disabled");
   a_write_resp: assert property (wr_do |=> s_axi_bvalid)
      else $error("write response missing");
   a_read_resp: assert property (rd_do |=> s_axi_rvalid)
      else $error("read response missing");

   // Extra guards on the counting sequence and the flag sources.
   a_read_clear: assert property (rd_flag & ~|set_flags & ~|irq_ack |=> flag_q == 3'h0)
      else $error("flag read did not clear flags");
   a_cmp_a_flag: assert property (tick & ~block_q & (count_q == cmp_a_q) |=> flag_q[1])
      else $error("compare a flag not set after match");
   a_phase_turn: assert property (tick & ~wr_count & phase & at_top & ~at_bottom
      |=> count_q == $past(count_q) - 8'h01)
      else $error("phase correct mode did not turn down at top");
   a_phase_bottom: assert property (tick & ~wr_count & phase & at_bottom & down_q
      |=> flag_q[0] & (count_q == 8'h01))
      else $error("phase correct mode did not turn up at bottom");
   a_fast_clear: assert property (tick & ~wr_count & fast & at_top
      |=> flag_q[0] & (count_q == 8'h00))
      else $error("fast mode did not clear and flag at top");
   a_power_hold: assert property (power_q & ~wr_count |=> $stable(count_q))
      else $error("counter moved while module disabled");

   c_ovf: cover property (ovf_event & mask_q[0]);
   c_cmp_a: cover property (match_a ##1 irq);
   c_phase_down: cover property (phase & tick & dir_down);
   c_ctc_clear: cover property (clear & (mode == timer_pkg::mode_ctc));
   c_block: cover property (wr_count ##1 block_q);
endmodule // timer_core

// File: src/timer_core_cfg.svh
`ifndef TIMER_CORE_CFG_SVH
`define TIMER_CORE_CFG_SVH

`define TC_ADDR_W 8
`define TC_OFF_CTRL_A 8'h00
`define TC_OFF_CTRL_B 8'h04
`define TC_OFF_COUNT 8'h08
`define TC_OFF_CMP_A 8'h0c
`define TC_OFF_CMP_B 8'h10
`define TC_OFF_FLAG 8'h14
`define TC_OFF_MASK 8'h18
`define TC_OFF_ASYNC 8'h1c
`define TC_OFF_POWER 8'h20

`define TC_FLAG_OVF 0
`define TC_FLAG_CMPA 1
`define TC_FLAG_CMPB 2
`define TC_FLAG_W 3

`define TC_WGM_LO_LSB 0
`define TC_CS_LSB 0
`define TC_WGM_HI_BIT 3
`define TC_ASYNC_BIT 0
`define TC_POWER_BIT 0

`define TC_BOTTOM 8'h00
`define TC_MAX 8'hff
`define TC_RST_BYTE 8'h00
`define TC_RST_POWER 1'b1

`define TC_RESP_OKAY 2'b00
`define TC_RESP_SLVERR 2'b10

`endif

// File: src/timer_pkg.sv
package timer_pkg;
   typedef enum logic [2:0] {
      mode_normal,
      mode_pc_max,
      mode_ctc,
      mode_fast_max,
      mode_rsvd4,
      mode_pc_top,
      mode_rsvd6,
      mode_fast_top
   } mode_e;
   typedef logic [7:0] byte_t;
endpackage

// File: src/tick_select.sv
`timescale 1ns/10ps
`include "timer_core_cfg.svh"
module tick_select (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic async_clock_select,
   input wire logic [2:0] clock_select_field,
   input wire logic enable,
   input wire logic crystal_pin_one,
   output logic tick
);
   logic sync1_q;
   logic sync2_q;
   logic sync3_q;
   logic tick_q;
   wire xtal_rise = sync2_q & ~sync3_q;
   wire src_event = async_clock_select ? xtal_rise : 1'b1;
   wire tick_d = enable & (clock_select_field != 3'h0) & src_event;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
         sync3_q <= 1'b0;
         tick_q <= 1'b0;
      end else begin
         sync1_q <= crystal_pin_one;
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
         tick_q <= tick_d;
      end
   end
   // The registered tick lags the controls by a cycle, so a stop or a power-down
   // must also gate it here, or one stray step slips through.
   assign tick = tick_q & enable & (clock_select_field != 3'h0);
endmodule // tick_select

// File: src/wave_gen.sv
`timescale 1ns/10ps
`include "timer_core_cfg.svh"
module wave_gen (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic tick,
   input wire timer_pkg::mode_e mode,
   input wire logic [7:0] count,
   input wire logic [7:0] compare_a,
   input wire logic [7:0] compare_b,
   output logic compare_output_a,
   output logic compare_output_b
);
   wire [7:0] cmp [2];
   logic out_q [2];
   wire pwm = (mode == timer_pkg::mode_pc_max) | (mode == timer_pkg::mode_fast_max) |
              (mode == timer_pkg::mode_pc_top) | (mode == timer_pkg::mode_fast_top);
   assign cmp[0] = compare_a;
   assign cmp[1] = compare_b;

   // PWM modes drive high while the count is below the compare value;
   // other modes toggle on each ticked match.
   for (genvar i = 0; i < 2; i++) begin : g_ch
      wire hit = tick & (count == cmp[i]);
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            out_q[i] <= 1'b0;
         end else if (pwm) begin
            out_q[i] <= (count < cmp[i]);
         end else if (hit) begin
            out_q[i] <= ~out_q[i];
         end
      end
   end
   assign compare_output_a = out_q[0];
   assign compare_output_b = out_q[1];
endmodule // wave_gen

// File: verification/tb_timer_core.sv
`timescale 1ns/10ps
`include "timer_core_cfg.svh"
module tb_timer_core;
   logic aclk;
   logic aresetn;
   logic [7:0] s_axi_awaddr;
   logic s_axi_awvalid;
   logic s_axi_awready;
   logic [31:0] s_axi_wdata;
   logic s_axi_wvalid;
   logic s_axi_wready;
   logic [1:0] s_axi_bresp;
   logic s_axi_bvalid;
   logic s_axi_bready;
   logic [7:0] s_axi_araddr;
   logic s_axi_arvalid;
   logic s_axi_arready;
   logic [31:0] s_axi_rdata;
   logic [1:0] s_axi_rresp;
   logic s_axi_rvalid;
   logic s_axi_rready;
   logic crystal_pin_one;
   logic [2:0] irq_ack;
   logic irq;
   logic compare_output_a;
   logic compare_output_b;
   int miscompares;
   int n_tests;
   logic [31:0] rv;
   logic [1:0] rr;
   logic [7:0] mode_a [4] = '{8'h00, 8'h02, 8'h03, 8'h03};
   logic [7:0] mode_b [4] = '{8'h01, 8'h01, 8'h01, 8'h09};
   logic [7:0] mode_exp [4] = '{8'h04, 8'h00, 8'h04, 8'h00};

   timer_core u_timer_core (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .crystal_pin_one(crystal_pin_one), .irq_ack(irq_ack),
      .irq(irq), .compare_output_a(compare_output_a), .compare_output_b(compare_output_b));

   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge aclk);
   endtask

   // Valid and payload stay up until the ready seen at an edge; bready is raised with them and held until bvalid.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      int n;
      n = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1 && n < 100);
      rr = s_axi_bresp;
      s_axi_bready <= 1'b0;
      if (n >= 100) chk("write_answer", 0, 1);
   endtask

   task automatic rd(input logic [7:0] a);
      int n;
      n = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1 && n < 100);
      rv = s_axi_rdata;
      rr = s_axi_rresp;
      s_axi_rready <= 1'b0;
      if (n >= 100) chk("read_answer", 0, 1);
   endtask

   // One rising edge of the crystal per loop, slow enough for the synchroniser.
   task automatic tick(input int n);
      repeat (n) begin
         crystal_pin_one <= 1'b1;
         idle(4);
         crystal_pin_one <= 1'b0;
         idle(4);
      end
      idle(4);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      #100000;
      miscompares++;
      finish_test();
   end

   initial begin
      aresetn = 1'b0;
      s_axi_awaddr = 8'h00;
      s_axi_awvalid = 1'b0;
      s_axi_wdata = 32'h0;
      s_axi_wvalid = 1'b0;
      s_axi_bready = 1'b0;
      s_axi_araddr = 8'h00;
      s_axi_arvalid = 1'b0;
      s_axi_rready = 1'b0;
      crystal_pin_one = 1'b0;
      irq_ack = 3'h0;
      idle(2);
      aresetn <= 1'b1;
      idle(1);
      rd(`TC_OFF_CTRL_A);
      chk("ctrl_a_reset", rv, 32'h0);
      rd(`TC_OFF_POWER);
      chk("power_reset", rv, 32'h1);
      rd(8'h24);
      chk("unmapped_read_resp", rr, `TC_RESP_SLVERR);
      wr(8'h24, 8'h5a);
      chk("unmapped_write_resp", rr, `TC_RESP_SLVERR);
      wr(`TC_OFF_CTRL_B, 8'h01);
      idle(10);
      rd(`TC_OFF_COUNT);
      chk("count_powered_down", rv, 32'h0);
      wr(`TC_OFF_POWER, 8'h00);
      wr(`TC_OFF_CTRL_B, 8'h00);
      wr(`TC_OFF_COUNT, 8'h5a);
      idle(10);
      rd(`TC_OFF_COUNT);
      chk("count_stopped", rv, 32'h5a);
      wr(`TC_OFF_CTRL_B, 8'h01);
      wr(`TC_OFF_COUNT, 8'h20);
      rd(`TC_OFF_COUNT);
      chk("count_after_write", {31'h0, (rv[7:0] - 8'h20) < 8'h10}, 32'h1);
      idle(300);
      rd(`TC_OFF_FLAG);
      chk("flags_after_wrap", rv, 32'h7);
      rd(`TC_OFF_FLAG);
      chk("flags_read_clear", rv, 32'h0);
      // From here on the tick comes only from crystal edges, so counts are exact.
      wr(`TC_OFF_ASYNC, 8'h01);
      wr(`TC_OFF_MASK, 8'h01);
      wr(`TC_OFF_COUNT, 8'hff);
      tick(1);
      rd(`TC_OFF_COUNT);
      chk("count_wrap", rv, 32'h0);
      chk("irq_ovf", {31'h0, irq}, 32'h1);
      wr(`TC_OFF_MASK, 8'h00);
      idle(2);
      chk("irq_masked", {31'h0, irq}, 32'h0);
      wr(`TC_OFF_FLAG, 8'h01);
      rd(`TC_OFF_FLAG);
      chk("ovf_write_one", rv, 32'h0);
      wr(`TC_OFF_CMP_B, 8'h05);
      wr(`TC_OFF_COUNT, 8'h04);
      tick(1);
      rd(`TC_OFF_FLAG);
      chk("cmp_b_before", rv & 32'h4, 32'h0);
      tick(1);
      rd(`TC_OFF_FLAG);
      chk("cmp_b_after", rv & 32'h4, 32'h4);
      wr(`TC_OFF_CMP_A, 8'h06);
      tick(2);
      wr(`TC_OFF_MASK, 8'h02);
      idle(3);
      chk("irq_cmp_a", {31'h0, irq}, 32'h1);
      irq_ack <= 3'h2;
      idle(1);
      irq_ack <= 3'h0;
      idle(3);
      chk("irq_after_ack", {31'h0, irq}, 32'h0);
      rd(`TC_OFF_FLAG);
      chk("cmp_a_acked", rv & 32'h2, 32'h0);
      wr(`TC_OFF_MASK, 8'h00);
      for (int i = 0; i < 4; i++) begin
         wr(`TC_OFF_CMP_A, 8'h03);
         wr(`TC_OFF_CTRL_A, mode_a[i]);
         wr(`TC_OFF_CTRL_B, mode_b[i]);
         wr(`TC_OFF_COUNT, 8'h02);
         tick(2);
         rd(`TC_OFF_COUNT);
         chk("count_mode", rv, {24'h0, mode_exp[i]});
      end
      wr(`TC_OFF_CTRL_A, 8'h03);
      wr(`TC_OFF_CTRL_B, 8'h01);
      wr(`TC_OFF_CMP_A, 8'h80);
      wr(`TC_OFF_CMP_B, 8'h10);
      wr(`TC_OFF_COUNT, 8'h40);
      idle(4);
      chk("pwm_out_a", {31'h0, compare_output_a}, 32'h1);
      chk("pwm_out_b", {31'h0, compare_output_b}, 32'h0);
      wr(`TC_OFF_CTRL_B, 8'h00);
      tick(2);
      rd(`TC_OFF_COUNT);
      chk("count_no_source", rv, 32'h40);
      wr(`TC_OFF_CTRL_A, 8'h01);
      wr(`TC_OFF_CTRL_B, 8'h01);
      wr(`TC_OFF_COUNT, 8'hfe);
      tick(4);
      rd(`TC_OFF_COUNT);
      chk("count_turn_down", rv, 32'hfc);
      finish_test();
   end
endmodule // tb_timer_core
